// ---- core/intc_pkg.sv ----
// Shared constants and types for the interrupt priority and status block
package intc_pkg;
  localparam int ADDR_W  = 8;
  localparam int DATA_W  = 32;
  localparam int UNIT_N  = 5;
  localparam int FAULT_N = 8;
  localparam int PRIO_W  = 4;
  localparam int LEVEL_W = 5;
  localparam int PRIO_N  = 16;
  localparam int SRC_W   = 10;
  localparam int ENTRY_W = 11;
  localparam int IRQ_N   = 3;

  // Register byte offsets
  localparam logic [ADDR_W-1:0] UNIT_STATUS_OFS     = 8'h00;
  localparam logic [ADDR_W-1:0] ROUTING_OFS         = 8'h04;
  localparam logic [ADDR_W-1:0] T0_PEND_PEEK_OFS    = 8'h08;
  localparam logic [ADDR_W-1:0] T0_PEND_TAKE_OFS    = 8'h0C;
  localparam logic [ADDR_W-1:0] T1_PEND_PEEK_OFS    = 8'h10;
  localparam logic [ADDR_W-1:0] T1_PEND_TAKE_OFS    = 8'h14;
  localparam logic [ADDR_W-1:0] T0_LEVEL_OFS        = 8'h18;
  localparam logic [ADDR_W-1:0] T1_LEVEL_OFS        = 8'h1C;
  localparam logic [ADDR_W-1:0] FAULT_RECORD_OFS    = 8'h20;
  localparam logic [ADDR_W-1:0] FAULT_SET_OFS       = 8'h24;
  localparam logic [ADDR_W-1:0] FAULT_CLEAR_OFS     = 8'h28;
  localparam logic [ADDR_W-1:0] FAULT_MASK_OFS      = 8'h2C;
  localparam logic [ADDR_W-1:0] FAULT_CHKSTP_EN_OFS = 8'h30;
  localparam logic [ADDR_W-1:0] FAULT_SYSERR_EN_OFS = 8'h34;
  localparam logic [ADDR_W-1:0] IRQ_STATUS_OFS      = 8'h38;
  localparam logic [ADDR_W-1:0] IRQ_MASK_OFS        = 8'h3C;

  // Field positions
  localparam int PP_VALID_BIT   = 31;
  localparam int PP_TYPE_BIT    = 30;
  localparam int PP_SRC_LSB     = 8;
  localparam int PP_PRIO_LSB    = 4;
  localparam int LEVEL_LSB      = 3;
  localparam int ROUTE_DEST_LSB = 0;
  localparam int ROUTE_PRIO_LSB = 4;
  localparam int IRQ_UNIT_BIT   = 0;
  localparam int IRQ_FAULT_BIT  = 1;
  localparam int IRQ_LOST_BIT   = 2;

  // Routing destinations
  localparam logic [1:0] DEST_RING_BUS = 2'h0;
  localparam logic [1:0] DEST_THREAD0  = 2'h1;
  localparam logic [1:0] DEST_THREAD1  = 2'h2;

  // Source fields of the class 1 entry the controller queues for itself
  localparam logic [1:0] CLASS1_CODE = 2'h1;
  localparam logic [3:0] SELF_NODE   = 4'h0;
  localparam logic [3:0] SELF_UNIT   = 4'hE;

  // Reset values
  localparam logic [LEVEL_W-1:0] LEVEL_RST   = 5'h00;
  localparam logic [7:0]         ROUTING_RST = 8'h00;

  typedef logic [PRIO_W-1:0]  prio_t;
  typedef logic [LEVEL_W-1:0] level_t;
  typedef logic [ENTRY_W-1:0] entry_t;
endpackage

// ---- core/pend_queue_if.sv ----
// Connection between the register core and one thread's pending queue
`timescale 1ns/10ps
interface pend_queue_if;
  import intc_pkg::*;
  logic   ins_valid;
  prio_t  ins_prio;
  entry_t ins_entry;
  logic   take;
  logic   head_valid;
  prio_t  head_prio;
  entry_t head_entry;
  logic   lost;

  modport ctrl (output ins_valid, ins_prio, ins_entry, take,
                input  head_valid, head_prio, head_entry, lost);
  modport queue (input  ins_valid, ins_prio, ins_entry, take,
                 output head_valid, head_prio, head_entry, lost);
endinterface

// ---- core/pend_queue.sv ----
// One entry per priority for one thread, best entry presented from a register
`timescale 1ns/10ps
module pend_queue
  import intc_pkg::*;
(
  input  wire logic  i_clk_sys, // System clock
  input  wire logic  i_resetn,  // Synchronous reset, active low
  pend_queue_if.queue q         // Insert, take and head
);
  typedef struct packed {
    logic [PRIO_N-1:0]            valid;
    logic [PRIO_N-1:0][ENTRY_W-1:0] entry;
    logic                         head_valid;
    prio_t                        head_prio;
    entry_t                       head_entry;
    logic                         lost;
  } queue_s;

  queue_s s_reg;
  queue_s s_next;

  always_comb
  begin
    s_next      = s_reg;
    s_next.lost = 1'b0;
    // Take removes the entry being presented
    if (q.take && s_reg.head_valid)
    begin
      s_next.valid[s_reg.head_prio] = 1'b0;
    end
    // An arrival overrides a take of the same slot so nothing is lost
    if (q.ins_valid)
    begin
      s_next.lost                 = s_reg.valid[q.ins_prio] &&
                                    !(q.take && s_reg.head_valid &&
                                      s_reg.head_prio == q.ins_prio);
      s_next.valid[q.ins_prio]    = 1'b1;
      s_next.entry[q.ins_prio]    = q.ins_entry;
    end
    // Masked entries simply stay here until the level lets them out
    s_next.head_valid = |s_next.valid;
    s_next.head_prio  = '0;
    s_next.head_entry = '0;
    for (int p = PRIO_N - 1; p >= 0; p--)
    begin
      if (s_next.valid[p])
      begin
        s_next.head_prio  = prio_t'(p);
        s_next.head_entry = s_next.entry[p];
      end
    end
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (!i_resetn)
      s_reg <= '0;
    else
      s_reg <= s_next;
  end

  assign q.head_valid = s_reg.head_valid;
  assign q.head_prio  = s_reg.head_prio;
  assign q.head_entry = s_reg.head_entry;
  assign q.lost       = s_reg.lost;
endmodule // pend_queue

// ---- core/interrupt_priority_status.sv ----
// Unit status, per-thread priority levels and fault isolation registers
`timescale 1ns/10ps
module interrupt_priority_status
  import intc_pkg::*;
(
  input  wire logic                        i_clk_sys,        // System clock, 10 MHz
  input  wire logic                        i_resetn,         // Synchronous reset, active low
  input  wire logic [intc_pkg::ADDR_W-1:0] i_addr,           // Register byte address
  input  wire logic [intc_pkg::DATA_W-1:0] i_wdata,          // Write data
  input  wire logic                        i_wr,             // Write strobe
  input  wire logic                        i_rd,             // Read strobe
  output      logic [intc_pkg::DATA_W-1:0] o_rdata,          // Read data, cycle after i_rd
  input  wire logic [intc_pkg::UNIT_N-1:0] i_unit_event,     // Unit condition pulses
  input  wire logic [intc_pkg::FAULT_N-1:0] i_fault_event,   // Fault detect pulses
  input  wire logic                        i_ext_valid,      // External interrupt arrival
  input  wire logic                        i_ext_thread,     // Target thread of arrival
  input  wire logic                        i_ext_type,       // Arrival type bit
  input  wire logic [intc_pkg::SRC_W-1:0]  i_ext_src,        // Class, node and unit of arrival
  input  wire intc_pkg::prio_t             i_ext_prio,       // Priority of arrival
  output      logic [1:0]                  o_ext_irq,        // External interrupt per thread
  output      logic                        o_ring_bus_class1, // Class 1 routed to ring bus
  output      logic                        o_checkstop,      // Checkstop interrupt
  output      logic                        o_system_error,   // System error interrupt
  output      logic                        o_irq             // Summary interrupt, level
);
  import intc_pkg::*;

  typedef struct packed {
    logic [UNIT_N-1:0]  unit_status;
    logic               unit_nz;
    logic               class1_pend;
    logic [7:0]         routing;
    level_t             level0;
    level_t             level1;
    logic [FAULT_N-1:0] fault_record;
    logic [FAULT_N-1:0] fault_mask;
    logic [FAULT_N-1:0] fault_chkstp_en;
    logic [FAULT_N-1:0] fault_syserr_en;
    logic [IRQ_N-1:0]   irq_status;
    logic [IRQ_N-1:0]   irq_mask;
    logic [DATA_W-1:0]  rdata;
    logic [1:0]         ext_irq;
    logic               ring_class1;
    logic               checkstop;
    logic               system_error;
    logic               irq;
  } core_s;

  core_s s_reg;
  core_s s_next;

  pend_queue_if q0 ();
  pend_queue_if q1 ();

  pend_queue u_queue0
  (
    .i_clk_sys (i_clk_sys),
    .i_resetn  (i_resetn),
    .q         (q0)
  );

  pend_queue u_queue1
  (
    .i_clk_sys (i_clk_sys),
    .i_resetn  (i_resetn),
    .q         (q1)
  );

  // Hardware set wins over a software clear in the same cycle
  function automatic logic [FAULT_N-1:0] clear_set(input logic [FAULT_N-1:0] old,
                                                   input logic [FAULT_N-1:0] clr,
                                                   input logic [FAULT_N-1:0] set);
    clear_set = (old & ~clr) | set;
  endfunction

  // Pending port word; fields not held read as zero
  function automatic logic [DATA_W-1:0] pend_word(input logic   valid,
                                                  input prio_t  prio,
                                                  input entry_t entry);
    logic [DATA_W-1:0] w;
    w = '0;
    if (valid)
    begin
      w[PP_VALID_BIT]                       = 1'b1;
      w[PP_TYPE_BIT]                        = entry[SRC_W];
      w[PP_SRC_LSB +: SRC_W]                = entry[SRC_W-1:0];
      w[PP_PRIO_LSB +: PRIO_W]              = prio;
    end
    pend_word = w;
  endfunction

  // Interrupt priority is placed in the top four of the five level bits
  function automatic logic unmasked(input logic valid, input prio_t prio,
                                    input level_t level);
    unmasked = valid && ({prio, 1'b0} < level);
  endfunction

  logic              wr_hit;
  logic [FAULT_N-1:0] wd_fault;
  logic [FAULT_N-1:0] fault_new;
  logic [FAULT_N-1:0] fault_base;
  logic [FAULT_N-1:0] fault_clr;
  logic [IRQ_N-1:0]   irq_event;
  logic [1:0]         dest;
  entry_t             class1_entry;
  logic               class1_to0;
  logic               class1_to1;

  always_comb
  begin
    s_next       = s_reg;
    wr_hit       = i_wr;
    wd_fault     = i_wdata[FAULT_N-1:0];
    dest         = s_reg.routing[ROUTE_DEST_LSB +: 2];
    class1_entry = {1'b0, CLASS1_CODE, SELF_NODE, SELF_UNIT};
    irq_event    = '0;

    q0.ins_valid = 1'b0;
    q0.ins_prio  = '0;
    q0.ins_entry = '0;
    q0.take      = 1'b0;
    q1.ins_valid = 1'b0;
    q1.ins_prio  = '0;
    q1.ins_entry = '0;
    q1.take      = 1'b0;

    // Unit condition status, write one to clear
    s_next.unit_status = s_reg.unit_status | i_unit_event;
    if (wr_hit && i_addr == UNIT_STATUS_OFS)
    begin
      s_next.unit_status = (s_reg.unit_status & ~i_wdata[UNIT_N-1:0]) |
                           i_unit_event;
    end
    s_next.unit_nz = |s_next.unit_status;
    irq_event[IRQ_UNIT_BIT] = s_next.unit_nz && !s_reg.unit_nz;

    // A fresh class 1 condition routed to a thread is queued once per rise of the status
    if (s_next.unit_nz && !s_reg.unit_nz &&
        (dest == DEST_THREAD0 || dest == DEST_THREAD1))
    begin
      s_next.class1_pend = 1'b1;
    end
    // Arrivals from outside take the queue port first; class 1 waits for a cycle with no arrival for its thread
    class1_to0 = s_reg.class1_pend && dest == DEST_THREAD0 &&
                 !(i_ext_valid && !i_ext_thread);
    class1_to1 = s_reg.class1_pend && dest == DEST_THREAD1 &&
                 !(i_ext_valid && i_ext_thread);
    if (class1_to0 || class1_to1)
      s_next.class1_pend = 1'b0;
    if (s_reg.class1_pend && dest != DEST_THREAD0 && dest != DEST_THREAD1)
      s_next.class1_pend = 1'b0;

    if (i_ext_valid && !i_ext_thread)
    begin
      q0.ins_valid = 1'b1;
      q0.ins_prio  = i_ext_prio;
      q0.ins_entry = {i_ext_type, i_ext_src};
    end
    else if (class1_to0)
    begin
      q0.ins_valid = 1'b1;
      q0.ins_prio  = s_reg.routing[ROUTE_PRIO_LSB +: PRIO_W];
      q0.ins_entry = class1_entry;
    end
    if (i_ext_valid && i_ext_thread)
    begin
      q1.ins_valid = 1'b1;
      q1.ins_prio  = i_ext_prio;
      q1.ins_entry = {i_ext_type, i_ext_src};
    end
    else if (class1_to1)
    begin
      q1.ins_valid = 1'b1;
      q1.ins_prio  = s_reg.routing[ROUTE_PRIO_LSB +: PRIO_W];
      q1.ins_entry = class1_entry;
    end
    irq_event[IRQ_LOST_BIT] = q0.lost | q1.lost;

    // Fault record: hardware detects, software set and clear points
    fault_new  = i_fault_event & ~s_reg.fault_mask;
    fault_base = s_reg.fault_record;
    fault_clr  = '0;
    if (wr_hit && i_addr == FAULT_RECORD_OFS)
      fault_base = wd_fault;
    if (wr_hit && i_addr == FAULT_SET_OFS)
      fault_new = fault_new | wd_fault;
    if (wr_hit && i_addr == FAULT_CLEAR_OFS)
      fault_clr = wd_fault;
    s_next.fault_record = clear_set(fault_base, fault_clr, fault_new);
    irq_event[IRQ_FAULT_BIT] = |(fault_new & ~s_reg.fault_record);

    if (wr_hit)
    begin
      case (i_addr)
        ROUTING_OFS:         s_next.routing = i_wdata[7:0];
        T0_LEVEL_OFS:        s_next.level0 = i_wdata[LEVEL_LSB +: LEVEL_W];
        T1_LEVEL_OFS:        s_next.level1 = i_wdata[LEVEL_LSB +: LEVEL_W];
        FAULT_MASK_OFS:      s_next.fault_mask = wd_fault;
        FAULT_CHKSTP_EN_OFS: s_next.fault_chkstp_en = wd_fault;
        FAULT_SYSERR_EN_OFS: s_next.fault_syserr_en = wd_fault;
        IRQ_MASK_OFS:        s_next.irq_mask = i_wdata[IRQ_N-1:0];
        default:             ;
      endcase
    end

    // Summary interrupt status, write one to clear, new events win
    s_next.irq_status = (s_reg.irq_status & ~((wr_hit && i_addr == IRQ_STATUS_OFS) ?
                         i_wdata[IRQ_N-1:0] : {IRQ_N{1'b0}})) | irq_event;

    // Read data stand the cycle after the strobe only
    s_next.rdata = '0;
    if (i_rd)
    begin
      case (i_addr)
        UNIT_STATUS_OFS:     s_next.rdata[UNIT_N-1:0] = s_reg.unit_status;
        ROUTING_OFS:         s_next.rdata[7:0] = s_reg.routing;
        T0_PEND_PEEK_OFS,
        T0_PEND_TAKE_OFS:    s_next.rdata = pend_word(q0.head_valid, q0.head_prio,
                                                      q0.head_entry);
        T1_PEND_PEEK_OFS,
        T1_PEND_TAKE_OFS:    s_next.rdata = pend_word(q1.head_valid, q1.head_prio,
                                                      q1.head_entry);
        T0_LEVEL_OFS:        s_next.rdata[LEVEL_LSB +: LEVEL_W] = s_reg.level0;
        T1_LEVEL_OFS:        s_next.rdata[LEVEL_LSB +: LEVEL_W] = s_reg.level1;
        FAULT_RECORD_OFS:    s_next.rdata[FAULT_N-1:0] = s_reg.fault_record;
        FAULT_MASK_OFS:      s_next.rdata[FAULT_N-1:0] = s_reg.fault_mask;
        FAULT_CHKSTP_EN_OFS: s_next.rdata[FAULT_N-1:0] = s_reg.fault_chkstp_en;
        FAULT_SYSERR_EN_OFS: s_next.rdata[FAULT_N-1:0] = s_reg.fault_syserr_en;
        IRQ_STATUS_OFS:      s_next.rdata[IRQ_N-1:0] = s_reg.irq_status;
        IRQ_MASK_OFS:        s_next.rdata[IRQ_N-1:0] = s_reg.irq_mask;
        default:             s_next.rdata = '0;
      endcase
      // Taking read moves the shown priority into the thread level
      if (i_addr == T0_PEND_TAKE_OFS)
      begin
        q0.take = 1'b1;
        if (q0.head_valid)
          s_next.level0 = {q0.head_prio, 1'b0};
      end
      if (i_addr == T1_PEND_TAKE_OFS)
      begin
        q1.take = 1'b1;
        if (q1.head_valid)
          s_next.level1 = {q1.head_prio, 1'b0};
      end
    end

    // Outputs, one register stage behind the state they follow
    s_next.ext_irq[0]   = unmasked(q0.head_valid, q0.head_prio, s_reg.level0);
    s_next.ext_irq[1]   = unmasked(q1.head_valid, q1.head_prio, s_reg.level1);
    s_next.ring_class1  = s_reg.unit_nz && dest == DEST_RING_BUS;
    s_next.checkstop    = |(s_reg.fault_record & s_reg.fault_chkstp_en);
    s_next.system_error = |(s_reg.fault_record & s_reg.fault_syserr_en);
    s_next.irq          = |(s_reg.irq_status & s_reg.irq_mask);
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (!i_resetn)
    begin
      s_reg         <= '0;
      s_reg.routing <= ROUTING_RST;
      s_reg.level0  <= LEVEL_RST;
      s_reg.level1  <= LEVEL_RST;
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  assign o_rdata           = s_reg.rdata;
  assign o_ext_irq         = s_reg.ext_irq;
  assign o_ring_bus_class1 = s_reg.ring_class1;
  assign o_checkstop       = s_reg.checkstop;
  assign o_system_error    = s_reg.system_error;
  assign o_irq             = s_reg.irq;
endmodule // interrupt_priority_status

// ---- dv/ext_thread_model.sv ----
// Far-side model: interrupt arrivals aimed at the two processor threads
`timescale 1ns/10ps
module ext_thread_model
  import intc_pkg::*;
(
  input  wire logic                       i_clk_sys,    // Clock
  output      logic                       o_ext_valid,  // Arrival pulse
  output      logic                       o_ext_thread, // Target thread
  output      logic                       o_ext_type,   // Type bit
  output      logic [intc_pkg::SRC_W-1:0] o_ext_src,    // Class, node, unit
  output      intc_pkg::prio_t            o_ext_prio    // Priority
);
  logic        req = 1'b0;
  logic [15:0] req_data = '0;

  initial
  begin
    o_ext_valid = 1'b0;
    {o_ext_thread, o_ext_type, o_ext_src, o_ext_prio} = '0;
  end

  // Idle fields flip every cycle so a stale value never passes for a request
  always @(posedge i_clk_sys)
  begin
    o_ext_valid <= req;
    if (req)
      {o_ext_thread, o_ext_type, o_ext_src, o_ext_prio} <= req_data;
    else
      {o_ext_thread, o_ext_type, o_ext_src, o_ext_prio} <= ~{o_ext_thread, o_ext_type,
                                                           o_ext_src, o_ext_prio};
    req = 1'b0;
  end

  task automatic send(input logic t, input logic ty, input logic [SRC_W-1:0] s,
                      input prio_t p);
    @(negedge i_clk_sys);
    req_data = {t, ty, s, p};
    req = 1'b1;
    @(posedge i_clk_sys);
    @(posedge i_clk_sys);
  endtask
endmodule // ext_thread_model

// ---- dv/interrupt_priority_status_assertions.sv ----
// Port-level assertions for the interrupt priority and status block
`timescale 1ns/10ps
module interrupt_priority_status_assertions
  import intc_pkg::*;
(
  input wire logic                         i_clk_sys,         // Clock
  input wire logic                         i_resetn,          // Reset
  input wire logic [intc_pkg::ADDR_W-1:0]  i_addr,            // Address
  input wire logic [intc_pkg::DATA_W-1:0]  i_wdata,           // Write data
  input wire logic                         i_wr,              // Write
  input wire logic                         i_rd,              // Read
  input wire logic [intc_pkg::DATA_W-1:0]  o_rdata,           // Read data
  input wire logic [intc_pkg::UNIT_N-1:0]  i_unit_event,      // Unit events
  input wire logic [1:0]                   o_ext_irq,         // Thread lines
  input wire logic                         o_ring_bus_class1, // Class 1 to bus
  input wire logic                         o_checkstop,       // Checkstop
  input wire logic                         o_system_error,    // System error
  input wire logic                         o_irq              // Summary
);
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_resetn);

  wire logic rd_lvl = i_rd && (i_addr == T0_LEVEL_OFS || i_addr == T1_LEVEL_OFS);
  wire logic rd_pend = i_rd && (i_addr inside {T0_PEND_PEEK_OFS, T0_PEND_TAKE_OFS,
                                               T1_PEND_PEEK_OFS, T1_PEND_TAKE_OFS});

  property p_level_width; rd_lvl |=> o_rdata[31:8] == '0 && o_rdata[2:0] == '0; endproperty
  a_level_width: assert property (p_level_width) else $error("level readback too wide");
  property p_level_write;
    i_wr && i_addr == T0_LEVEL_OFS ##1 i_rd && i_addr == T0_LEVEL_OFS
      |=> o_rdata[7:3] == $past(i_wdata[7:3], 2);
  endproperty
  a_level_write: assert property (p_level_write) else $error("level write lost");
  property p_pend_zero;
    rd_pend |=> o_rdata[29:18] == '0 && o_rdata[3:0] == '0 && (o_rdata[31] || o_rdata == '0);
  endproperty
  a_pend_zero: assert property (p_pend_zero) else $error("pending word spare bits");
  property p_take_level;
    i_rd && i_addr == T0_PEND_TAKE_OFS ##1 o_rdata[31] && i_rd && i_addr == T0_LEVEL_OFS
      |=> o_rdata[7:3] == {$past(o_rdata[7:4]), 1'b0};
  endproperty
  a_take_level: assert property (p_take_level) else $error("take did not load level");
  property p_status_w1c;
    i_wr && i_addr == UNIT_STATUS_OFS && i_wdata[4:0] == 5'h1F && i_unit_event == '0
      ##1 i_rd && i_addr == UNIT_STATUS_OFS && i_unit_event == '0 |=> o_rdata == '0;
  endproperty
  a_status_w1c: assert property (p_status_w1c) else $error("status not cleared");
  property p_chkstp_off;
    i_wr && i_addr == FAULT_CHKSTP_EN_OFS && i_wdata[7:0] == '0 |-> ##2 !o_checkstop;
  endproperty
  a_chkstp_off: assert property (p_chkstp_off) else $error("checkstop not gated");
  property p_syserr_off;
    i_wr && i_addr == FAULT_SYSERR_EN_OFS && i_wdata[7:0] == '0 |-> ##2 !o_system_error;
  endproperty
  a_syserr_off: assert property (p_syserr_off) else $error("system error not gated");
  property p_t0_level0;
    i_wr && i_addr == T0_LEVEL_OFS && i_wdata[7:3] == '0 |-> ##2 !o_ext_irq[0];
  endproperty
  a_t0_level0: assert property (p_t0_level0) else $error("thread 0 not masked");
  property p_t1_level0;
    i_wr && i_addr == T1_LEVEL_OFS && i_wdata[7:3] == '0 |-> ##2 !o_ext_irq[1];
  endproperty
  a_t1_level0: assert property (p_t1_level0) else $error("thread 1 not masked");
  property p_route_away;
    i_wr && i_addr == ROUTING_OFS && i_wdata[1:0] != DEST_RING_BUS |-> ##2 !o_ring_bus_class1;
  endproperty
  a_route_away: assert property (p_route_away) else $error("class 1 misrouted");
endmodule // interrupt_priority_status_assertions

bind interrupt_priority_status interrupt_priority_status_assertions
  i_interrupt_priority_status_assertions (.*);

// ---- dv/interrupt_priority_status_tb.sv ----
// Self-checking bench for the interrupt priority and status block
`timescale 1ns/10ps
module interrupt_priority_status_tb;
  import intc_pkg::*;
  logic               i_clk_sys = 1'b0;
  logic               i_resetn = 1'b0;
  logic [ADDR_W-1:0]  i_addr = '0;
  logic [DATA_W-1:0]  i_wdata = '0;
  logic               i_wr = 1'b0;
  logic               i_rd = 1'b0;
  logic [UNIT_N-1:0]  i_unit_event = '0;
  logic [FAULT_N-1:0] i_fault_event = '0;
  logic [DATA_W-1:0]  o_rdata;
  logic               ext_valid, ext_thread, ext_type, o_ring_bus_class1;
  logic               o_checkstop, o_system_error, o_irq;
  logic [SRC_W-1:0]   ext_src;
  prio_t              ext_prio;
  logic [1:0]         o_ext_irq;
  logic [DATA_W-1:0]  rdq;
  logic [5:0]         outq;
  logic [UNIT_N-1:0]  ue = '0;
  logic [FAULT_N-1:0] fe = '0;
  int                 num_errors = 0;
  int                 check_count = 0;

  always #50 i_clk_sys = ~i_clk_sys;

  interrupt_priority_status i_interrupt_priority_status (
    .i_clk_sys(i_clk_sys), .i_resetn(i_resetn), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_unit_event(i_unit_event),
    .i_fault_event(i_fault_event), .i_ext_valid(ext_valid), .i_ext_thread(ext_thread),
    .i_ext_type(ext_type), .i_ext_src(ext_src), .i_ext_prio(ext_prio),
    .o_ext_irq(o_ext_irq), .o_ring_bus_class1(o_ring_bus_class1),
    .o_checkstop(o_checkstop), .o_system_error(o_system_error), .o_irq(o_irq));
  ext_thread_model i_ext_thread_model (
    .i_clk_sys(i_clk_sys), .o_ext_valid(ext_valid), .o_ext_thread(ext_thread),
    .o_ext_type(ext_type), .o_ext_src(ext_src), .o_ext_prio(ext_prio));

  task automatic chk(input string nm, input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] ex);
    check_count++;
    if (seen !== ex)
    begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", nm, ex, seen);
    end
  endtask

  // One bus cycle; outputs sampled mid-cycle
  task automatic cyc(input logic w, input logic r, input logic [ADDR_W-1:0] a,
                     input logic [DATA_W-1:0] d);
    i_wr <= w;
    i_rd <= r;
    i_addr <= a;
    i_wdata <= d;
    i_unit_event <= ue;
    i_fault_event <= fe;
    ue = '0;
    fe = '0;
    @(negedge i_clk_sys);
    rdq = o_rdata;
    outq = {o_ring_bus_class1, o_checkstop, o_system_error, o_irq, o_ext_irq};
    @(posedge i_clk_sys);
  endtask
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    cyc(1'b1, 1'b0, a, d);
    cyc(1'b0, 1'b0, a, '0);
  endtask
  task automatic rchk(input string nm, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] ex);
    cyc(1'b0, 1'b1, a, '0);
    cyc(1'b0, 1'b0, a, '0);
    chk(nm, rdq, ex);
  endtask
  // Outputs lag the state by up to three edges, so let four pass
  task automatic ochk(input string nm, input logic [5:0] ex);
    repeat (4) cyc(1'b0, 1'b0, '0, '0);
    chk(nm, {26'h0, outq}, {26'h0, ex});
  endtask

  task automatic t_reset();
    cyc(1'b0, 1'b0, '0, '0);
    chk("outputs at reset", {26'h0, outq}, '0);
    rchk("level0 reset", T0_LEVEL_OFS, '0);
    rchk("level1 reset", T1_LEVEL_OFS, '0);
    rchk("unmapped read", 8'hFC, '0);
    rchk("empty port", T0_PEND_PEEK_OFS, '0);
  endtask
  task automatic t_lowest();
    wr(T0_LEVEL_OFS, 32'hFFFFFFFF);
    rchk("level0 width", T0_LEVEL_OFS, 32'h000000F8);
    i_ext_thread_model.send(1'b0, 1'b0, 10'h3A5, 4'hF);
    ochk("prio F unmasked", 6'h01);
    wr(T0_LEVEL_OFS, 32'h000000F0);
    ochk("equal level masks", 6'h00);
    wr(T0_LEVEL_OFS, 32'h000000F8);
    ochk("still pending", 6'h01);
    rchk("peek F", T0_PEND_PEEK_OFS, 32'h8003A5F0);
    rchk("take F", T0_PEND_TAKE_OFS, 32'h8003A5F0);
    rchk("level from F", T0_LEVEL_OFS, 32'h000000F0);
    rchk("port drained", T0_PEND_PEEK_OFS, '0);
  endtask
  task automatic t_order();
    i_ext_thread_model.send(1'b0, 1'b1, 10'h000, 4'h8);
    i_ext_thread_model.send(1'b0, 1'b0, 10'h155, 4'h0);
    rchk("zero first", T0_PEND_PEEK_OFS, 32'h80015500);
    cyc(1'b0, 1'b1, T0_PEND_TAKE_OFS, '0);
    cyc(1'b0, 1'b1, T0_LEVEL_OFS, '0);
    chk("take 0", rdq, 32'h80015500);
    cyc(1'b0, 1'b0, '0, '0);
    chk("level 0 loaded", rdq, '0);
    ochk("prio 8 deferred", 6'h00);
    rchk("next best", T0_PEND_PEEK_OFS, 32'hC0000080);
    wr(T0_LEVEL_OFS, 32'h00000080);
    ochk("level 10 masks prio 8", 6'h00);
    cyc(1'b1, 1'b0, T0_LEVEL_OFS, 32'h00000088);
    cyc(1'b0, 1'b1, T0_LEVEL_OFS, '0);
    cyc(1'b0, 1'b0, '0, '0);
    chk("level write", rdq, 32'h00000088);
    ochk("level 11 passes prio 8", 6'h01);
    rchk("take 8", T0_PEND_TAKE_OFS, 32'hC0000080);
    rchk("level from 8", T0_LEVEL_OFS, 32'h00000080);
  endtask
  task automatic t_thread1();
    wr(T1_LEVEL_OFS, 32'h000000F8);
    wr(T0_LEVEL_OFS, '0);
    i_ext_thread_model.send(1'b1, 1'b0, 10'h2C3, 4'h5);
    ochk("thread 1 only", 6'h02);
    rchk("thread 0 empty", T0_PEND_PEEK_OFS, '0);
    rchk("take t1", T1_PEND_TAKE_OFS, 32'h8002C350);
    rchk("level1 from 5", T1_LEVEL_OFS, 32'h00000050);
    wr(T1_LEVEL_OFS, '0);
    ochk("t1 quiet", 6'h00);
  endtask
  task automatic t_unit();
    wr(IRQ_MASK_OFS, 32'h1);
    ue = 5'h15;
    cyc(1'b0, 1'b0, '0, '0);
    rchk("status capture", UNIT_STATUS_OFS, 32'h15);
    ochk("class 1 on bus", 6'h24);
    wr(UNIT_STATUS_OFS, 32'h1);
    rchk("one bit cleared", UNIT_STATUS_OFS, 32'h14);
    wr(IRQ_STATUS_OFS, 32'h1);
    ochk("summary cleared", 6'h20);
    cyc(1'b1, 1'b0, UNIT_STATUS_OFS, 32'h1F);
    cyc(1'b0, 1'b1, UNIT_STATUS_OFS, '0);
    cyc(1'b0, 1'b0, '0, '0);
    chk("all cleared", rdq, '0);
    wr(T0_LEVEL_OFS, 32'h000000F8);
    wr(ROUTING_OFS, 32'h21);
    ue = 5'h02;
    cyc(1'b0, 1'b0, '0, '0);
    ochk("class 1 to thread 0", 6'h05);
    rchk("class 1 entry", T0_PEND_TAKE_OFS, 32'h80010E20);
    wr(UNIT_STATUS_OFS, 32'h1F);
    wr(IRQ_STATUS_OFS, 32'h7);
    wr(T0_LEVEL_OFS, '0);
  endtask
  task automatic t_fault();
    wr(IRQ_MASK_OFS, 32'h2);
    wr(FAULT_MASK_OFS, 32'h01);
    fe = 8'h03;
    cyc(1'b0, 1'b0, '0, '0);
    rchk("masked capture", FAULT_RECORD_OFS, 32'h02);
    ochk("fault summary", 6'h04);
    wr(FAULT_SET_OFS, 32'h80);
    rchk("set", FAULT_RECORD_OFS, 32'h82);
    wr(FAULT_CLEAR_OFS, 32'h02);
    rchk("clear", FAULT_RECORD_OFS, 32'h80);
    wr(FAULT_CHKSTP_EN_OFS, 32'h80);
    ochk("checkstop", 6'h14);
    wr(FAULT_SYSERR_EN_OFS, 32'h02);
    ochk("syserr gated", 6'h14);
    wr(FAULT_SYSERR_EN_OFS, 32'h80);
    ochk("syserr", 6'h1C);
    wr(FAULT_CHKSTP_EN_OFS, '0);
    wr(FAULT_SYSERR_EN_OFS, '0);
    wr(IRQ_STATUS_OFS, 32'h2);
    ochk("faults quiet", 6'h00);
    wr(IRQ_MASK_OFS, 32'h4);
    i_ext_thread_model.send(1'b1, 1'b0, 10'h001, 4'h3);
    i_ext_thread_model.send(1'b1, 1'b0, 10'h002, 4'h3);
    ochk("entry overwritten", 6'h04);
  endtask

  task automatic tally_and_finish();
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  initial
  begin
    repeat (4) @(posedge i_clk_sys);
    i_resetn <= 1'b1;
    @(posedge i_clk_sys);
    t_reset();
    t_lowest();
    t_order();
    t_thread1();
    t_unit();
    t_fault();
    tally_and_finish();
  end

  initial
  begin
    repeat (3000) @(posedge i_clk_sys);
    num_errors++;
    tally_and_finish();
  end
endmodule // interrupt_priority_status_tb
